// >>> logic/pc_peak_monitor_parity_mask.sv
// register bank: program counter peak monitor and data memory zero parity masks
//
// Notes on behaviour
// - the highest pc seen in the last frame, or last block in block mode, is captured and readable.
// - the frame peak is 24 bits, upper 8 in the low byte of one register, lower 16 in the next.
// - a running maximum of frame peaks since start is kept and grows when a new peak exceeds it.
// - the running maximum is 24 bits, split 8 and 16 over two adjacent read-only registers.
// - the clear control zeroes both the frame peak and the running maximum.
// - each parity mask bit works per subbank: 0 reports errors, 1 ignores them.
// - the first mask register holds bank 1 at bits 12..8 and bank 0 at bits 4..0, gaps reserved.
// - the second mask register holds bank 3 at bits 12..8 and bank 2 at bits 4..0, same gaps.
// - every mask bit is read-write and resets to zero so all subbanks report after reset.
// - while the clear bit is 1 the pc is held at zero and does not update.
// - the live pc is 24 bits, readable as bits 23..16 and then bits 15..0.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pc_peak_monitor_parity_mask (
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	input  wire logic [pc_peak_pkg::ADDR_W-1:0]      avs_address,
	input  wire logic                                avs_read,
	input  wire logic                                avs_write,
	input  wire logic [pc_peak_pkg::DATA_W-1:0]      avs_writedata,
	input  wire logic [3:0]                          avs_byteenable,
	output logic      [pc_peak_pkg::DATA_W-1:0]      avs_readdata,
	output logic                                     avs_waitrequest,
	input  wire logic [pc_peak_pkg::PC_W-1:0]        pc_value,
	input  wire logic                                pc_valid,
	input  wire logic                                frame_start,
	input  wire logic                                block_start,
	input  wire logic                                block_mode,
	input  wire logic [pc_peak_pkg::ERR_W-1:0]       dm0_parity_err,
	output logic                                     pc_hold,
	output logic                                     panic,
	output logic                                     irq
);

	typedef struct packed {
		logic                                waitrequest;
		logic [pc_peak_pkg::DATA_W-1:0]      rdata;
		logic                                clear;
		logic [pc_peak_pkg::PC_W-1:0]        live_pc;
		logic [pc_peak_pkg::REG_W-1:0]       mask_lo;
		logic [pc_peak_pkg::REG_W-1:0]       mask_hi;
		logic [pc_peak_pkg::EVT_W-1:0]       status;
		logic [pc_peak_pkg::EVT_W-1:0]       irq_en;
		logic                                irq;
	} state_type;

	state_type                          st_ff;
	state_type                          nxt_st;
	logic                               wr_commit;
	logic                               rd_take;
	logic                               boundary;
	logic [pc_peak_pkg::DATA_W-1:0]     rd_word;
	logic [pc_peak_pkg::REG_W-1:0]      wr_lane;
	logic [pc_peak_pkg::EVT_W-1:0]      events;
	logic [pc_peak_pkg::EVT_W-1:0]      w1c;
	logic [pc_peak_pkg::PC_W-1:0]       frame_peak;
	logic [pc_peak_pkg::PC_W-1:0]       max_peak;
	logic                               max_upd;
	logic                               frame_done;
	logic                               panic_hit;
	logic [pc_peak_pkg::ERR_W-1:0]      ignore_mask;

	// block boundary replaces the frame boundary when block processing runs
	assign boundary = block_mode ? block_start : frame_start;

	// bank order 0..3, five subbanks each, subbank 0 lowest
	assign ignore_mask = {pc_peak_pkg::bank_pair(st_ff.mask_hi), pc_peak_pkg::bank_pair(st_ff.mask_lo)};

	pc_peak_tracker tracker (
		.clk        (clk),
		.arst_n     (arst_n),
		.pc_value   (pc_value),
		.pc_valid   (pc_valid),
		.boundary   (boundary),
		.clear      (st_ff.clear),
		.frame_peak (frame_peak),
		.max_peak   (max_peak),
		.max_upd    (max_upd),
		.frame_done (frame_done)
	);

	parity_panic_gate gate (
		.clk         (clk),
		.arst_n      (arst_n),
		.parity_err  (dm0_parity_err),
		.ignore_mask (ignore_mask),
		.panic       (panic_hit)
	);

	always_comb begin
		nxt_st = st_ff;
		rd_word = '0;
		wr_lane = '0;
		w1c = pc_peak_pkg::RST_EVT;
		events = '0;

		// one wait cycle, then a single low cycle in which the access completes
		wr_commit = avs_write && !st_ff.waitrequest;
		rd_take = avs_read && st_ff.waitrequest;
		nxt_st.waitrequest = !((avs_read || avs_write) && st_ff.waitrequest);

		case (avs_address)
			pc_peak_pkg::ADDR_PC_HI: begin
				rd_word = 32'(st_ff.live_pc[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT]);
			end
			pc_peak_pkg::ADDR_PC_LO: begin
				rd_word = 32'(st_ff.live_pc[pc_peak_pkg::PC_SPLIT-1:0]);
			end
			pc_peak_pkg::ADDR_PC_CLEAR: begin
				rd_word = 32'(st_ff.clear);
			end
			pc_peak_pkg::ADDR_FRAME_PEAK_HI: begin
				rd_word = 32'(frame_peak[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT]);
			end
			pc_peak_pkg::ADDR_FRAME_PEAK_LO: begin
				rd_word = 32'(frame_peak[pc_peak_pkg::PC_SPLIT-1:0]);
			end
			pc_peak_pkg::ADDR_MAX_PEAK_HI: begin
				rd_word = 32'(max_peak[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT]);
			end
			pc_peak_pkg::ADDR_MAX_PEAK_LO: begin
				rd_word = 32'(max_peak[pc_peak_pkg::PC_SPLIT-1:0]);
			end
			pc_peak_pkg::ADDR_PARITY_LO: begin
				rd_word = 32'(st_ff.mask_lo);
			end
			pc_peak_pkg::ADDR_PARITY_HI: begin
				rd_word = 32'(st_ff.mask_hi);
			end
			pc_peak_pkg::ADDR_IRQ_STATUS: begin
				rd_word = 32'(st_ff.status);
			end
			pc_peak_pkg::ADDR_IRQ_ENABLE: begin
				rd_word = 32'(st_ff.irq_en);
			end
			default: begin
				rd_word = '0;
			end
		endcase
		if (rd_take) begin
			nxt_st.rdata = rd_word;
		end

		// peak registers are read-only; writes to them and to holes are dropped
		if (wr_commit) begin
			case (avs_address)
				pc_peak_pkg::ADDR_PC_CLEAR: begin
					wr_lane = pc_peak_pkg::merge16(16'(st_ff.clear), avs_writedata[15:0], avs_byteenable[1:0]);
					nxt_st.clear = wr_lane[pc_peak_pkg::CLEAR_BIT];
				end
				pc_peak_pkg::ADDR_PARITY_LO: begin
					wr_lane = pc_peak_pkg::merge16(st_ff.mask_lo, avs_writedata[15:0], avs_byteenable[1:0]);
					nxt_st.mask_lo = wr_lane & pc_peak_pkg::PARITY_FIELDS;
				end
				pc_peak_pkg::ADDR_PARITY_HI: begin
					wr_lane = pc_peak_pkg::merge16(st_ff.mask_hi, avs_writedata[15:0], avs_byteenable[1:0]);
					nxt_st.mask_hi = wr_lane & pc_peak_pkg::PARITY_FIELDS;
				end
				pc_peak_pkg::ADDR_IRQ_STATUS: begin
					if (avs_byteenable[0]) begin
						w1c = avs_writedata[pc_peak_pkg::EVT_W-1:0];
					end
				end
				pc_peak_pkg::ADDR_IRQ_ENABLE: begin
					if (avs_byteenable[0]) begin
						nxt_st.irq_en = avs_writedata[pc_peak_pkg::EVT_W-1:0];
					end
				end
				default: begin
					wr_lane = '0;
				end
			endcase
		end

		// held at zero from the very cycle the clear bit becomes 1
		if (nxt_st.clear) begin
			nxt_st.live_pc = '0;
		end else if (pc_valid) begin
			nxt_st.live_pc = pc_value;
		end

		events[pc_peak_pkg::EVT_PANIC] = panic_hit;
		events[pc_peak_pkg::EVT_MAX] = max_upd;
		events[pc_peak_pkg::EVT_FRAME] = frame_done;
		// set beats a simultaneous write-one clear
		nxt_st.status = (st_ff.status & ~w1c) | events;
		nxt_st.irq = |(nxt_st.status & nxt_st.irq_en);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
			st_ff.waitrequest <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata    = st_ff.rdata;
	assign avs_waitrequest = st_ff.waitrequest;
	assign pc_hold         = st_ff.clear;
	assign panic           = panic_hit;
	assign irq             = st_ff.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	bus_wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	bus_wait_back_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	bus_idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without a request");

	rdata_upper_zero_a: assert property (avs_readdata[31:16] == '0)
		else $error("read data upper half not zero");
	rdata_stands_a: assert property (!rd_take |=> $stable(avs_readdata))
		else $error("read data changed without a read");

	frame_hi_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_FRAME_PEAK_HI
		|=> avs_readdata == 32'($past(frame_peak[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT])))
		else $error("frame peak upper byte read wrong");
	max_lo_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_MAX_PEAK_LO
		|=> avs_readdata == 32'($past(max_peak[pc_peak_pkg::PC_SPLIT-1:0])))
		else $error("running maximum lower half read wrong");
	live_pc_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_PC_HI
		|=> avs_readdata == 32'($past(st_ff.live_pc[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT])))
		else $error("live pc upper byte read wrong");

	frame_lo_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_FRAME_PEAK_LO
		|=> avs_readdata == 32'($past(frame_peak[pc_peak_pkg::PC_SPLIT-1:0])))
		else $error("frame peak lower half read wrong");

	max_hi_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_MAX_PEAK_HI
		|=> avs_readdata == 32'($past(max_peak[pc_peak_pkg::PC_W-1:pc_peak_pkg::PC_SPLIT])))
		else $error("running maximum upper byte read wrong");

	live_pc_lo_read_a: assert property (
		rd_take && avs_address == pc_peak_pkg::ADDR_PC_LO
		|=> avs_readdata == 32'($past(st_ff.live_pc[pc_peak_pkg::PC_SPLIT-1:0])))
		else $error("live pc lower half read wrong");

	pc_held_zero_a: assert property (pc_hold |-> st_ff.live_pc == '0)
		else $error("live pc nonzero while clear is held");
	pc_resume_a: assert property (!nxt_st.clear && pc_valid |=> st_ff.live_pc == $past(pc_value))
		else $error("live pc did not follow while clear is low");

	clear_write_a: assert property (
		wr_commit && avs_address == pc_peak_pkg::ADDR_PC_CLEAR && avs_byteenable[0]
		|=> pc_hold == $past(avs_writedata[pc_peak_pkg::CLEAR_BIT]))
		else $error("clear bit write wrong");

	mask_lo_write_a: assert property (
		wr_commit && avs_address == pc_peak_pkg::ADDR_PARITY_LO && avs_byteenable[1:0] == 2'b11
		|=> st_ff.mask_lo == ($past(avs_writedata[15:0]) & pc_peak_pkg::PARITY_FIELDS))
		else $error("first mask register write wrong");
	mask_hi_write_a: assert property (
		wr_commit && avs_address == pc_peak_pkg::ADDR_PARITY_HI && avs_byteenable[1:0] == 2'b11
		|=> st_ff.mask_hi == ($past(avs_writedata[15:0]) & pc_peak_pkg::PARITY_FIELDS))
		else $error("second mask register write wrong");
	bank3_map_a: assert property (st_ff.mask_hi[12] |-> ignore_mask[19])
		else $error("bank 3 subbank 4 mask misplaced");

	bank_order_a: assert property (ignore_mask == {st_ff.mask_hi[12:8], st_ff.mask_hi[4:0],
		st_ff.mask_lo[12:8], st_ff.mask_lo[4:0]})
		else $error("subbank mask order wrong");
	mask_rsvd_a: assert property (
		((st_ff.mask_lo | st_ff.mask_hi) & ~pc_peak_pkg::PARITY_FIELDS) == '0)
		else $error("reserved mask bits stored");

	panic_set_wins_a: assert property (panic_hit |=> st_ff.status[pc_peak_pkg::EVT_PANIC])
		else $error("panic event lost in status");
	irq_level_a: assert property ((st_ff.status & st_ff.irq_en) == '0 |-> !irq)
		else $error("interrupt high with nothing pending");

	irq_pending_a: assert property ((st_ff.status & st_ff.irq_en) != '0 |-> irq)
		else $error("interrupt low with an event pending");

	frame_event_a: assert property (frame_done |=> st_ff.status[pc_peak_pkg::EVT_FRAME])
		else $error("frame event lost in status");

	max_event_a: assert property (max_upd |=> st_ff.status[pc_peak_pkg::EVT_MAX])
		else $error("maximum event lost in status");

	status_w1c_a: assert property (
		wr_commit && avs_address == pc_peak_pkg::ADDR_IRQ_STATUS && avs_byteenable[0] && events == '0
		|=> (st_ff.status & $past(avs_writedata[pc_peak_pkg::EVT_W-1:0])) == '0)
		else $error("write one did not clear status");

endmodule // pc_peak_monitor_parity_mask

// >>> logic/pc_peak_pkg.sv
// shared constants, register map and helper functions for the pc peak monitor
package pc_peak_pkg;

	localparam int ADDR_W   = 18;
	localparam int DATA_W   = 32;
	localparam int REG_W    = 16;
	localparam int PC_W     = 24;
	localparam int PC_SPLIT = 16;
	localparam int BANKS    = 4;
	localparam int SUBBANKS = 5;
	localparam int ERR_W    = BANKS * SUBBANKS;
	localparam int EVT_W    = 3;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_PC_HI         = 16'hf460;
	localparam logic [15:0] IDX_PC_LO         = 16'hf461;
	localparam logic [15:0] IDX_PC_CLEAR      = 16'hf462;
	localparam logic [15:0] IDX_FRAME_PEAK_HI = 16'hf463;
	localparam logic [15:0] IDX_FRAME_PEAK_LO = 16'hf464;
	localparam logic [15:0] IDX_MAX_PEAK_HI   = 16'hf465;
	localparam logic [15:0] IDX_MAX_PEAK_LO   = 16'hf466;
	localparam logic [15:0] IDX_PARITY_LO     = 16'hf467;
	localparam logic [15:0] IDX_PARITY_HI     = 16'hf468;
	localparam logic [15:0] IDX_IRQ_STATUS    = 16'hf470;
	localparam logic [15:0] IDX_IRQ_ENABLE    = 16'hf471;

	localparam logic [ADDR_W-1:0] ADDR_PC_HI         = {IDX_PC_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PC_LO         = {IDX_PC_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PC_CLEAR      = {IDX_PC_CLEAR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FRAME_PEAK_HI = {IDX_FRAME_PEAK_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FRAME_PEAK_LO = {IDX_FRAME_PEAK_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MAX_PEAK_HI   = {IDX_MAX_PEAK_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MAX_PEAK_LO   = {IDX_MAX_PEAK_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PARITY_LO     = {IDX_PARITY_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PARITY_HI     = {IDX_PARITY_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS    = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE    = {IDX_IRQ_ENABLE, 2'b00};

	// field positions and reset values
	localparam int                CLEAR_BIT     = 0;
	localparam int                ODD_BANK_LSB  = 8;
	localparam int                EVEN_BANK_LSB = 0;
	localparam logic [REG_W-1:0]  PARITY_FIELDS = 16'h1f1f;
	localparam logic [REG_W-1:0]  RST_REG       = 16'h0000;
	localparam logic [EVT_W-1:0]  RST_EVT       = 3'h0;
	localparam int                EVT_PANIC     = 0;
	localparam int                EVT_MAX       = 1;
	localparam int                EVT_FRAME     = 2;

	function automatic logic [PC_W-1:0] max_pc(input logic [PC_W-1:0] a, input logic [PC_W-1:0] b);
		max_pc = (a > b) ? a : b;
	endfunction

	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old, input logic [REG_W-1:0] wd,
		input logic [1:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// two banks of one mask register, even bank in the low five bits
	function automatic logic [2*SUBBANKS-1:0] bank_pair(input logic [REG_W-1:0] r);
		bank_pair = {r[ODD_BANK_LSB +: SUBBANKS], r[EVEN_BANK_LSB +: SUBBANKS]};
	endfunction

endpackage

// >>> logic/pc_peak_tracker.sv
// per-frame program counter peak and running maximum
`timescale 1ns/1ps
module pc_peak_tracker (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic [pc_peak_pkg::PC_W-1:0]  pc_value,
	input  wire logic                          pc_valid,
	input  wire logic                          boundary,
	input  wire logic                          clear,
	output logic      [pc_peak_pkg::PC_W-1:0]  frame_peak,
	output logic      [pc_peak_pkg::PC_W-1:0]  max_peak,
	output logic                               max_upd,
	output logic                               frame_done
);
	typedef struct packed {
		logic [pc_peak_pkg::PC_W-1:0] run_peak;
		logic [pc_peak_pkg::PC_W-1:0] frame_peak;
		logic [pc_peak_pkg::PC_W-1:0] max_peak;
		logic                         max_upd;
		logic                         frame_done;
	} trk_type;

	trk_type st_ff;
	trk_type nxt_st;
	logic [pc_peak_pkg::PC_W-1:0] cand;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.max_upd = 1'b0;
		nxt_st.frame_done = 1'b0;
		cand = pc_valid ? pc_peak_pkg::max_pc(st_ff.run_peak, pc_value) : st_ff.run_peak;
		if (clear) begin
			nxt_st = '0;
		end else if (boundary) begin
			nxt_st.frame_peak = cand;
			nxt_st.run_peak = '0;
			nxt_st.frame_done = 1'b1;
			nxt_st.max_peak = pc_peak_pkg::max_pc(st_ff.max_peak, cand);
			nxt_st.max_upd = cand > st_ff.max_peak;
		end else begin
			nxt_st.run_peak = cand;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign frame_peak = st_ff.frame_peak;
	assign max_peak   = st_ff.max_peak;
	assign max_upd    = st_ff.max_upd;
	assign frame_done = st_ff.frame_done;

	frame_capture_a: assert property (@(posedge clk) disable iff (!arst_n)
		boundary && !clear && pc_valid |=> frame_peak >= $past(pc_value))
		else $error("frame peak below a pc seen in the frame");
	max_covers_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
		max_peak >= frame_peak)
		else $error("running maximum below frame peak");
	max_monotone_a: assert property (@(posedge clk) disable iff (!arst_n)
		!clear |=> max_peak >= $past(max_peak))
		else $error("running maximum decreased without clear");
	clear_zeroes_a: assert property (@(posedge clk) disable iff (!arst_n)
		clear |=> frame_peak == '0 && max_peak == '0)
		else $error("peaks not zero after clear");

endmodule // pc_peak_tracker

// >>> logic/parity_panic_gate.sv
// per-subbank parity error masking into one panic pulse
`timescale 1ns/1ps
module parity_panic_gate (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire logic [pc_peak_pkg::ERR_W-1:0]  parity_err,
	input  wire logic [pc_peak_pkg::ERR_W-1:0]  ignore_mask,
	output logic                                panic
);
	typedef struct packed {
		logic hit;
	} gate_type;

	gate_type st_ff;
	gate_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.hit = |(parity_err & ~ignore_mask);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign panic = st_ff.hit;

	unmasked_raises_a: assert property (@(posedge clk) disable iff (!arst_n)
		|(parity_err & ~ignore_mask) |=> panic)
		else $error("unmasked parity error gave no panic");
	masked_silent_a: assert property (@(posedge clk) disable iff (!arst_n)
		(parity_err & ~ignore_mask) == '0 |=> !panic)
		else $error("panic raised by ignored subbank");

endmodule // parity_panic_gate

// >>> test/tb_top.sv
// self-checking testbench for the pc peak monitor and parity mask register bank
`timescale 1ns/1ps
module tb_top;
	logic                            clk;
	logic                            arst_n;
	logic [pc_peak_pkg::ADDR_W-1:0]  avs_address;
	logic                            avs_read;
	logic                            avs_write;
	logic [pc_peak_pkg::DATA_W-1:0]  avs_writedata;
	logic [3:0]                      avs_byteenable;
	logic [pc_peak_pkg::DATA_W-1:0]  avs_readdata;
	logic                            avs_waitrequest;
	logic [pc_peak_pkg::PC_W-1:0]    pc_value;
	logic                            pc_valid;
	logic                            frame_start;
	logic                            block_start;
	logic                            block_mode;
	logic [pc_peak_pkg::ERR_W-1:0]   dm0_parity_err;
	logic                            pc_hold;
	logic                            panic;
	logic                            irq;
	int                              num_errors;
	int                              tests_run;

	pc_peak_monitor_parity_mask dut (
		.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pc_value(pc_value), .pc_valid(pc_valid),
		.frame_start(frame_start), .block_start(block_start), .block_mode(block_mode),
		.dm0_parity_err(dm0_parity_err), .pc_hold(pc_hold), .panic(panic), .irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_sim();
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	// the master waits up to 20 cycles for waitrequest low; a stuck waitrequest ends the run
	task automatic wait_answer(output logic [31:0] data);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			check("waitrequest", 32'h0, {31'h0, avs_waitrequest});
			end_sim();
		end else begin
			data = avs_readdata;
		end
	endtask

	task automatic bus_write(input logic [17:0] addr, input logic [15:0] data, input logic [1:0] be);
		logic [31:0] d;
		@(posedge clk);
		avs_address    <= addr;
		avs_writedata  <= {16'h0000, data};
		avs_byteenable <= {2'b00, be};
		avs_write      <= 1'b1;
		wait_answer(d);
		avs_write      <= 1'b0;
	endtask

	task automatic expect_reg(input string what, input logic [17:0] addr, input logic [15:0] exp);
		logic [31:0] d;
		@(posedge clk);
		avs_address <= addr;
		avs_read    <= 1'b1;
		wait_answer(d);
		avs_read    <= 1'b0;
		check(what, {16'h0000, exp}, d);
	endtask

	// hi register holds bits 23..16 in its low byte, the next one bits 15..0
	task automatic expect_pair(input string what, input logic [17:0] hi, input logic [23:0] exp);
		expect_reg(what, hi, {8'h00, exp[23:16]});
		expect_reg(what, hi + 18'h4, exp[15:0]);
	endtask

	task automatic drive_pc(input logic [23:0] v, input logic vld);
		@(posedge clk);
		pc_value <= v;
		pc_valid <= vld;
	endtask

	task automatic boundary(input logic blk);
		@(posedge clk);
		pc_valid <= 1'b0;
		if (blk) block_start <= 1'b1;
		else frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		block_start <= 1'b0;
		@(posedge clk);
	endtask

	task automatic err_pulse(input logic [19:0] e, input logic exp);
		@(posedge clk);
		dm0_parity_err <= e;
		@(posedge clk);
		dm0_parity_err <= '0;
		#1 check("panic", {31'h0, exp}, {31'h0, panic});
		@(posedge clk);
		#1 check("panic end", 32'h0, {31'h0, panic});
	endtask

	task automatic test_reset();
		logic [17:0] a [12];
		a = '{pc_peak_pkg::ADDR_PC_HI, pc_peak_pkg::ADDR_PC_LO, pc_peak_pkg::ADDR_PC_CLEAR,
			pc_peak_pkg::ADDR_FRAME_PEAK_HI, pc_peak_pkg::ADDR_FRAME_PEAK_LO, pc_peak_pkg::ADDR_MAX_PEAK_HI,
			pc_peak_pkg::ADDR_MAX_PEAK_LO, pc_peak_pkg::ADDR_PARITY_LO, pc_peak_pkg::ADDR_PARITY_HI,
			pc_peak_pkg::ADDR_IRQ_STATUS, pc_peak_pkg::ADDR_IRQ_ENABLE, {16'hf47f, 2'b00}};
		foreach (a[i]) expect_reg("reset value", a[i], 16'h0000);
	endtask

	task automatic test_masks();
		bus_write(pc_peak_pkg::ADDR_PARITY_LO, 16'hffff, 2'b11);
		expect_reg("mask low", pc_peak_pkg::ADDR_PARITY_LO, 16'h1f1f);
		bus_write(pc_peak_pkg::ADDR_PARITY_HI, 16'ha5a5, 2'b11);
		expect_reg("mask high", pc_peak_pkg::ADDR_PARITY_HI, 16'h0505);
		bus_write(pc_peak_pkg::ADDR_PARITY_LO, 16'h0000, 2'b01);
		expect_reg("mask lane", pc_peak_pkg::ADDR_PARITY_LO, 16'h1f00);
		bus_write(pc_peak_pkg::ADDR_FRAME_PEAK_LO, 16'h1234, 2'b11);
		expect_reg("peak write", pc_peak_pkg::ADDR_FRAME_PEAK_LO, 16'h0000);
		bus_write({16'hf47f, 2'b00}, 16'hffff, 2'b11);
		expect_reg("unmapped", {16'hf47f, 2'b00}, 16'h0000);
		bus_write(pc_peak_pkg::ADDR_PARITY_LO, 16'h0000, 2'b11);
		bus_write(pc_peak_pkg::ADDR_PARITY_HI, 16'h0000, 2'b11);
	endtask

	task automatic test_peaks();
		drive_pc(24'h123456, 1'b1);
		drive_pc(24'habcdef, 1'b1);
		drive_pc(24'hffffff, 1'b0);
		drive_pc(24'h010000, 1'b1);
		boundary(1'b0);
		expect_pair("frame peak", pc_peak_pkg::ADDR_FRAME_PEAK_HI, 24'habcdef);
		expect_pair("max peak", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'habcdef);
		drive_pc(24'h001234, 1'b1);
		drive_pc(24'hfffff0, 1'b0);
		boundary(1'b0);
		expect_pair("lower frame", pc_peak_pkg::ADDR_FRAME_PEAK_HI, 24'h001234);
		expect_pair("max kept", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'habcdef);
		drive_pc(24'hfffffe, 1'b1);
		boundary(1'b0);
		expect_pair("max grown", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'hfffffe);
	endtask

	// frame starts must not close a block while block processing is on
	task automatic test_block();
		@(posedge clk);
		block_mode <= 1'b1;
		drive_pc(24'h000500, 1'b1);
		boundary(1'b0);
		drive_pc(24'h000400, 1'b1);
		boundary(1'b1);
		expect_pair("block peak", pc_peak_pkg::ADDR_FRAME_PEAK_HI, 24'h000500);
		expect_pair("block max", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'hfffffe);
		@(posedge clk);
		block_mode <= 1'b0;
	endtask

	task automatic test_clear();
		bus_write(pc_peak_pkg::ADDR_PC_CLEAR, 16'h0001, 2'b11);
		drive_pc(24'h777777, 1'b1);
		boundary(1'b0);
		#1 check("pc hold", 32'h1, {31'h0, pc_hold});
		expect_reg("clear reg", pc_peak_pkg::ADDR_PC_CLEAR, 16'h0001);
		expect_pair("cleared frame", pc_peak_pkg::ADDR_FRAME_PEAK_HI, 24'h000000);
		expect_pair("cleared max", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'h000000);
		drive_pc(24'h345678, 1'b1);
		expect_pair("held pc", pc_peak_pkg::ADDR_PC_HI, 24'h000000);
		drive_pc(24'h345678, 1'b0);
		bus_write(pc_peak_pkg::ADDR_PC_CLEAR, 16'h0000, 2'b11);
		drive_pc(24'h123456, 1'b1);
		@(posedge clk);
		#1 check("pc hold off", 32'h0, {31'h0, pc_hold});
		expect_pair("live pc", pc_peak_pkg::ADDR_PC_HI, 24'h123456);
		drive_pc(24'h000777, 1'b1);
		boundary(1'b0);
		expect_pair("restart frame", pc_peak_pkg::ADDR_FRAME_PEAK_HI, 24'h123456);
		drive_pc(24'h000777, 1'b1);
		boundary(1'b0);
		expect_pair("restart max", pc_peak_pkg::ADDR_MAX_PEAK_HI, 24'h123456);
	endtask

	// one subbank masked at a time; its neighbour must still report
	task automatic test_parity();
		int b;
		logic [15:0] m;
		for (int i = 0; i < 20; i++) begin
			b = i / 5;
			m = 16'h0001 << (((b % 2) * 8) + (i % 5));
			bus_write(pc_peak_pkg::ADDR_PARITY_LO, (b < 2) ? m : 16'h0000, 2'b11);
			bus_write(pc_peak_pkg::ADDR_PARITY_HI, (b < 2) ? 16'h0000 : m, 2'b11);
			err_pulse(20'h00001 << i, 1'b0);
			err_pulse(20'h00001 << ((i + 1) % 20), 1'b1);
		end
		bus_write(pc_peak_pkg::ADDR_PARITY_LO, 16'h0000, 2'b11);
		bus_write(pc_peak_pkg::ADDR_PARITY_HI, 16'h0000, 2'b11);
	endtask

	task automatic irq_is(input string what, input logic exp);
		@(posedge clk);
		@(posedge clk);
		#1 check(what, {31'h0, exp}, {31'h0, irq});
	endtask

	task automatic test_irq();
		bus_write(pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0007, 2'b01);
		expect_reg("status cleared", pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0000);
		bus_write(pc_peak_pkg::ADDR_IRQ_ENABLE, 16'h0001, 2'b11);
		err_pulse(20'h80000, 1'b1);
		irq_is("irq panic", 1'b1);
		expect_reg("status panic", pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0001);
		bus_write(pc_peak_pkg::ADDR_IRQ_ENABLE, 16'h0000, 2'b11);
		irq_is("irq masked", 1'b0);
		bus_write(pc_peak_pkg::ADDR_IRQ_ENABLE, 16'h0004, 2'b11);
		bus_write(pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0001, 2'b01);
		irq_is("irq clear", 1'b0);
		boundary(1'b0);
		irq_is("irq frame", 1'b1);
		expect_reg("status frame", pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0004);
		drive_pc(24'h7fffff, 1'b1);
		boundary(1'b0);
		expect_reg("status max", pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0006);
		bus_write(pc_peak_pkg::ADDR_IRQ_STATUS, 16'h0007, 2'b01);
		irq_is("irq final", 1'b0);
	endtask

	initial begin
		num_errors     = 0;
		tests_run      = 0;
		arst_n         = 1'b0;
		avs_address    = '0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = '0;
		avs_byteenable = 4'h0;
		pc_value       = '0;
		pc_valid       = 1'b0;
		frame_start    = 1'b0;
		block_start    = 1'b0;
		block_mode     = 1'b0;
		dm0_parity_err = '0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		test_reset();
		test_masks();
		test_peaks();
		test_block();
		test_clear();
		test_parity();
		test_irq();
		end_sim();
	end
endmodule // tb_top
